/* File: rtl/dcr_pkg.sv */
// dcr_pkg: offsets, field positions, reset values for the dma command regs
// assumes an 8-bit isa-style i/o window with a 4-bit register offset
package dcr_pkg;
  // ----------------------------------------------------------------------
  // register offsets (low four bits of the i/o address)
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFF_SOFT_REQUEST = 4'h9;
  localparam logic [3:0] OFF_SINGLE_CHANNEL_MASK = 4'hA;
  localparam logic [3:0] OFF_CHANNEL_TRANSFER_SETUP = 4'hB;
  localparam logic [3:0] OFF_BYTE_POINTER_RESET = 4'hC;
  localparam logic [3:0] OFF_LAST_MOVED_BYTE = 4'hD;
  localparam logic [3:0] OFF_CONTROLLER_SOFT_RESET = 4'hD;
  localparam logic [3:0] OFF_UNMASK_ALL_CHANNELS = 4'hE;
  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int SEL_LSB = 0;
  localparam int ASSERT_OR_DROP_BIT = 2;
  localparam int TYPE_LSB = 2;
  localparam int AUTO_INIT_BIT = 4;
  localparam int STEP_DIR_BIT = 5;
  localparam int MODE_LSB = 6;
  localparam int MEMORY_COPY_ENABLE_BIT = 0;
  // ----------------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_DEMAND = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_BLOCK = 2'h2;
  localparam logic [1:0] MODE_CASCADE = 2'h3;
  localparam logic [1:0] TYPE_VERIFY = 2'h0;
  localparam logic [1:0] TYPE_ILLEGAL = 2'h3;
  localparam logic [3:0] RST_CHAN4 = 4'h0;
  localparam logic [3:0] RST_MASK4 = 4'hF;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic RST_BIT = 1'b0;
endpackage

/* File: rtl/dcr_chan_mode.sv */
// dcr_chan_mode: stored mode word of one dma channel
// assumes writes come from the register decoder on the same clock
`timescale 1ns/10ps
module dcr_chan_mode (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic wr_i,
  input wire logic [7:0] data_i,
  input wire logic memory_copy_enable_i,
  output logic [1:0] mode_o,
  output logic address_step_direction_o,
  output logic auto_init_o,
  output logic [1:0] transfer_type_field_o
);
  logic [1:0] next_mode;
  logic next_dir;
  logic next_ai;
  logic [1:0] next_type;
  logic [1:0] type_raw;

  // ----------------------------------------------------------------------
  // next state: load whole mode word on a selected write
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_mode = mode_o;
    next_dir = address_step_direction_o;
    next_ai = auto_init_o;
    next_type = type_raw;
    if (clr_i)
    begin
      next_mode = dcr_pkg::MODE_DEMAND;
      next_dir = dcr_pkg::RST_BIT;
      next_ai = dcr_pkg::RST_BIT;
      next_type = dcr_pkg::TYPE_VERIFY;
    end
    else if (wr_i)
    begin
      next_mode = data_i[dcr_pkg::MODE_LSB +: 2];
      next_dir = data_i[dcr_pkg::STEP_DIR_BIT];
      next_ai = data_i[dcr_pkg::AUTO_INIT_BIT];
      next_type = data_i[dcr_pkg::TYPE_LSB +: 2];
    end
  end

  // registers only
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      mode_o <= dcr_pkg::MODE_DEMAND;
      address_step_direction_o <= dcr_pkg::RST_BIT;
      auto_init_o <= dcr_pkg::RST_BIT;
      type_raw <= dcr_pkg::TYPE_VERIFY;
    end
    else
    begin
      mode_o <= next_mode;
      address_step_direction_o <= next_dir;
      auto_init_o <= next_ai;
      type_raw <= next_type;
    end
  end

  // type is don't-care in cascade or memory copy; forced to verify there
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      transfer_type_field_o <= dcr_pkg::TYPE_VERIFY;
    else if (next_mode == dcr_pkg::MODE_CASCADE || memory_copy_enable_i)
      transfer_type_field_o <= dcr_pkg::TYPE_VERIFY;
    else
      transfer_type_field_o <= next_type;
  end
endmodule // dcr_chan_mode

/* File: rtl/dcr_temp_hold.sv */
// dcr_temp_hold: holding register of the last memory-copy byte
// assumes the transfer engine pulses capture_i with the moved byte
`timescale 1ns/10ps
module dcr_temp_hold (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic capture_i,
  input wire logic [7:0] byte_i,
  output logic [7:0] byte_o
);
  logic [7:0] next_byte;

  // capture wins over clear: a byte landing with master clear is kept
  always_comb
  begin
    next_byte = byte_o;
    if (capture_i)
      next_byte = byte_i;
    else if (clr_i)
      next_byte = dcr_pkg::RST_BYTE;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      byte_o <= dcr_pkg::RST_BYTE;
    else
      byte_o <= next_byte;
  end
endmodule // dcr_temp_hold

/* File: rtl/dcr_regs.sv */
// dcr_regs: write-side command and mode registers of a 4-channel dma
// assumes a synchronous i/o strobe interface from the isa window decoder
`timescale 1ns/10ps
// Contract
// - request write sets or clears one channel's software request by bit 2.
// - single mask write sets or clears one channel's mask, others kept.
// - mode write stores transfer mode, step direction and auto-init.
// - mode write affects only the channel in its low two bits.
// - bits 3:2 give verify, write or read; software never writes 11.
// - transfer type ignored in cascade mode or with memory copy enabled.
// - any write at 0xC clears the byte pointer toggle.
// - read at 0xD returns last byte of latest memory copy.
// - any write at 0xD resets all controller registers like hardware reset; a temp byte captured in that same cycle is kept.
// - any write at 0xE clears all four channel masks.
// - toggle zero selects low byte, one selects high byte of 16-bit regs.
module dcr_regs #(
  parameter int NUM_CH = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [3:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic word_reg_access_i,
  input wire logic [7:0] controller_command_i,
  input wire logic temp_capture_i,
  input wire logic [7:0] temp_byte_i,
  output logic [7:0] io_rdata_o,
  output logic io_rvalid_o,
  output logic [NUM_CH-1:0] soft_req_o,
  output logic [NUM_CH-1:0] chan_mask_o,
  output logic [2*NUM_CH-1:0] mode_o,
  output logic [NUM_CH-1:0] address_step_direction_o,
  output logic [NUM_CH-1:0] auto_init_o,
  output logic [2*NUM_CH-1:0] transfer_type_field_o,
  output logic byte_pointer_toggle_o,
  output logic software_master_clear_o
);
  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  logic wr_req;
  logic wr_mask;
  logic wr_mode;
  logic wr_bp;
  logic wr_clr;
  logic wr_unmask;
  logic memory_copy_enable;
  logic [1:0] sel;
  logic setbit;
  logic [7:0] temp_q;

  // one-hot channel pick from the two select bits
  function automatic logic [NUM_CH-1:0] chan_dec(input logic [1:0] s);
    chan_dec = '0;
    chan_dec[s] = 1'b1;
  endfunction

  assign sel = io_wdata_i[dcr_pkg::SEL_LSB +: 2];
  assign setbit = io_wdata_i[dcr_pkg::ASSERT_OR_DROP_BIT];
  assign memory_copy_enable =
    controller_command_i[dcr_pkg::MEMORY_COPY_ENABLE_BIT];
  // strobes per register
  assign wr_req = io_wr_i && io_addr_i == dcr_pkg::OFF_SOFT_REQUEST;
  assign wr_mask = io_wr_i && io_addr_i == dcr_pkg::OFF_SINGLE_CHANNEL_MASK;
  assign wr_mode = io_wr_i &&
    io_addr_i == dcr_pkg::OFF_CHANNEL_TRANSFER_SETUP;
  assign wr_bp = io_wr_i && io_addr_i == dcr_pkg::OFF_BYTE_POINTER_RESET;
  assign wr_clr = io_wr_i && io_addr_i == dcr_pkg::OFF_CONTROLLER_SOFT_RESET;
  assign wr_unmask = io_wr_i &&
    io_addr_i == dcr_pkg::OFF_UNMASK_ALL_CHANNELS;

  // ----------------------------------------------------------------------
  // request, mask and byte pointer state
  // ----------------------------------------------------------------------
  logic [NUM_CH-1:0] next_req;
  logic [NUM_CH-1:0] next_mask;
  logic next_bp;
  logic next_mclr;

  // ----------------------------------------------------------------------
  // software request group
  // ----------------------------------------------------------------------
  // bits 7:3 of a request write are never looked at, so reserved ones
  // written by careless software cannot reach another channel
  always_comb
  begin
    next_req = soft_req_o;
    if (wr_clr)
      next_req = dcr_pkg::RST_CHAN4[NUM_CH-1:0];
    else if (wr_req && setbit)
      next_req = soft_req_o | chan_dec(sel);
    else if (wr_req)
      next_req = soft_req_o & ~chan_dec(sel);
  end

  // registers only
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      soft_req_o <= dcr_pkg::RST_CHAN4[NUM_CH-1:0];
    else
      soft_req_o <= next_req;
  end

  // ----------------------------------------------------------------------
  // channel mask group
  // ----------------------------------------------------------------------
  // unmask-all outranks a single mask write; the offsets differ, so the
  // order only fixes intent should the decoder ever change
  always_comb
  begin
    next_mask = chan_mask_o;
    if (wr_clr)
      next_mask = dcr_pkg::RST_MASK4[NUM_CH-1:0];
    else if (wr_unmask)
      next_mask = '0;
    else if (wr_mask && setbit)
      next_mask = chan_mask_o | chan_dec(sel);
    else if (wr_mask)
      next_mask = chan_mask_o & ~chan_dec(sel);
  end

  // registers only
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      chan_mask_o <= dcr_pkg::RST_MASK4[NUM_CH-1:0];
    else
      chan_mask_o <= next_mask;
  end

  // ----------------------------------------------------------------------
  // byte pointer group
  // ----------------------------------------------------------------------
  // clear write wins over a same-cycle byte access flip, so software
  // that clears first always starts on the low byte
  always_comb
  begin
    next_bp = byte_pointer_toggle_o;
    if (wr_clr)
      next_bp = dcr_pkg::RST_BIT;
    else if (wr_bp)
      next_bp = dcr_pkg::RST_BIT;
    else if (word_reg_access_i)
      next_bp = ~byte_pointer_toggle_o;
  end

  // registers only
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      byte_pointer_toggle_o <= dcr_pkg::RST_BIT;
    else
      byte_pointer_toggle_o <= next_bp;
  end

  // ----------------------------------------------------------------------
  // master clear pulse
  // ----------------------------------------------------------------------
  // one-cycle flag so the transfer engine can drop back to idle as well
  always_comb
  begin
    next_mclr = wr_clr;
  end

  // registers only
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      software_master_clear_o <= dcr_pkg::RST_BIT;
    else
      software_master_clear_o <= next_mclr;
  end

  // ----------------------------------------------------------------------
  // per-channel mode words
  // ----------------------------------------------------------------------
  logic [NUM_CH-1:0] mode_wr;
  assign mode_wr = wr_mode ? chan_dec(sel) : '0;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      dcr_chan_mode u_mode (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .clr_i(wr_clr),
        .wr_i(mode_wr[g]),
        .data_i(io_wdata_i),
        .memory_copy_enable_i(memory_copy_enable),
        .mode_o(mode_o[2*g +: 2]),
        .address_step_direction_o(address_step_direction_o[g]),
        .auto_init_o(auto_init_o[g]),
        .transfer_type_field_o(transfer_type_field_o[2*g +: 2])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // temporary byte and read path
  // ----------------------------------------------------------------------
  dcr_temp_hold u_temp (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .clr_i(wr_clr),
    .capture_i(temp_capture_i),
    .byte_i(temp_byte_i),
    .byte_o(temp_q)
  );

  logic [7:0] next_rdata;
  logic next_rvalid;

  // only offset 0xD reads back here; other offsets answer zero
  always_comb
  begin
    next_rvalid = io_rd_i;
    next_rdata = 8'h00;
    if (io_rd_i && io_addr_i == dcr_pkg::OFF_LAST_MOVED_BYTE)
      next_rdata = temp_q;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      io_rdata_o <= dcr_pkg::RST_BYTE;
      io_rvalid_o <= dcr_pkg::RST_BIT;
    end
    else
    begin
      io_rdata_o <= next_rdata;
      io_rvalid_o <= next_rvalid;
    end
  end
endmodule // dcr_regs

/* File: sim/dcr_regs_asserts.sv */
// dcr_regs_asserts: port-level checks of the dma command registers
// assumes it is bound onto dcr_regs and shares its clock and reset
`timescale 1ns/10ps
module dcr_regs_asserts #(
  parameter int NUM_CH = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic io_wr_i,
  input wire logic [3:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] controller_command_i,
  input wire logic [NUM_CH-1:0] soft_req_o,
  input wire logic [NUM_CH-1:0] chan_mask_o,
  input wire logic [2*NUM_CH-1:0] mode_o,
  input wire logic [2*NUM_CH-1:0] transfer_type_field_o,
  input wire logic byte_pointer_toggle_o,
  input wire logic software_master_clear_o
);
  // ----------------------------------------------------------------
  // write effects, one cycle after the strobe edge
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  req_write_a: assert property (io_wr_i && io_addr_i == 4'h9 |=>
    soft_req_o[$past(io_wdata_i[1:0])] == $past(io_wdata_i[2]))
    else $error("request bit not set as written");
  mask_write_a: assert property (io_wr_i && io_addr_i == 4'hA |=>
    chan_mask_o[$past(io_wdata_i[1:0])] == $past(io_wdata_i[2]))
    else $error("mask bit not set as written");
  mode_write_a: assert property (io_wr_i && io_addr_i == 4'hB |=>
    mode_o[2*$past(io_wdata_i[1:0]) +: 2] == $past(io_wdata_i[7:6]))
    else $error("mode field not stored");
  mode_others_a: assert property (io_wr_i && io_addr_i == 4'hB |=>
    ((mode_o ^ $past(mode_o)) & ~(8'h03 << 2*$past(io_wdata_i[1:0])))
    == 8'h00) else $error("mode write touched another channel");
  ptr_clear_a: assert property (io_wr_i && io_addr_i == 4'hC |=>
    !byte_pointer_toggle_o) else $error("byte pointer not cleared");
  master_clear_a: assert property (io_wr_i && io_addr_i == 4'hD |=>
    software_master_clear_o && chan_mask_o == 4'hF && soft_req_o == 4'h0
    && mode_o == 8'h00) else $error("master clear incomplete");
  unmask_all_a: assert property (io_wr_i && io_addr_i == 4'hE |=>
    chan_mask_o == 4'h0) else $error("masks not all cleared");
  // type field must read zero once memory copy has been on two cycles
  copy_type_a: assert property (controller_command_i[0] &&
    $past(controller_command_i[0]) |-> transfer_type_field_o == 8'h00)
    else $error("type field kept during memory copy");
endmodule // dcr_regs_asserts

/* File: sim/dcr_engine_model.sv */
// dcr_engine_model: stand-in for the transfer engine and peripherals
// assumes bench requests arrive just after a rising clock edge
`timescale 1ns/10ps
module dcr_engine_model (
  input wire logic core_clk_i,
  input wire logic step_i,
  input wire logic copy_go_i,
  input wire logic [7:0] copy_byte_i,
  output logic word_access_o = 1'b0,
  output logic capture_o = 1'b0,
  output logic [7:0] byte_o = 8'h00
);
  // one-cycle pulses; the byte bus inverts when idle so stale data shows
  always_ff @(posedge core_clk_i)
  begin
    word_access_o <= step_i;
    capture_o <= copy_go_i;
    byte_o <= copy_go_i ? copy_byte_i : ~byte_o;
  end
endmodule // dcr_engine_model

/* File: sim/test_dcr_regs.sv */
// test_dcr_regs: self-checking bench for the dma command registers
// assumes dcr_regs, the engine model and the checker are compiled first
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  mismatches++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module test_dcr_regs;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic [3:0] io_addr_i = 4'h0;
  logic [7:0] io_wdata_i = 8'h00;
  logic [7:0] controller_command_i = 8'h00;
  logic step = 1'b0;
  logic go = 1'b0;
  logic [7:0] gbyte = 8'h00;
  logic word_reg_access_i, temp_capture_i, io_rvalid_o;
  logic byte_pointer_toggle_o, software_master_clear_o;
  logic [7:0] temp_byte_i, io_rdata_o, mode_o, transfer_type_field_o;
  logic [3:0] soft_req_o, chan_mask_o, address_step_direction_o;
  logic [3:0] auto_init_o;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  // ----------------------------------------------------------------
  // clock, hang guard, design and far side
  // ----------------------------------------------------------------
  initial
  begin
    forever #4 core_clk_i = ~core_clk_i;
  end
  // whole run is under a hundred cycles
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      end_of_test();
    end
  end
  dcr_regs #(.NUM_CH(4)) dut (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i),
    .io_addr_i(io_addr_i),
    .io_wdata_i(io_wdata_i),
    .word_reg_access_i(word_reg_access_i),
    .controller_command_i(controller_command_i),
    .temp_capture_i(temp_capture_i),
    .temp_byte_i(temp_byte_i),
    .io_rdata_o(io_rdata_o),
    .io_rvalid_o(io_rvalid_o),
    .soft_req_o(soft_req_o),
    .chan_mask_o(chan_mask_o),
    .mode_o(mode_o),
    .address_step_direction_o(address_step_direction_o),
    .auto_init_o(auto_init_o),
    .transfer_type_field_o(transfer_type_field_o),
    .byte_pointer_toggle_o(byte_pointer_toggle_o),
    .software_master_clear_o(software_master_clear_o)
  );
  dcr_engine_model u_eng (.core_clk_i(core_clk_i), .step_i(step),
    .copy_go_i(go), .copy_byte_i(gbyte), .word_access_o(word_reg_access_i),
    .capture_o(temp_capture_i), .byte_o(temp_byte_i));
  // ----------------------------------------------------------------
  // bus tasks and scenarios
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    #1 io_wr_i = 1'b1;
    io_addr_i = a;
    io_wdata_i = d;
    @(posedge core_clk_i);
    #1 io_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    #1 io_rd_i = 1'b1;
    io_addr_i = a;
    @(posedge core_clk_i);
    #1 io_rd_i = 1'b0;
    `CHK("rvalid", 1'b1, io_rvalid_o)
    `CHK("rdata", e, io_rdata_o)
  endtask
  // engine request lands at the design two edges later
  task automatic eng(input logic s, input logic g, input logic [7:0] b);
    @(posedge core_clk_i);
    #1 step = s;
    go = g;
    gbyte = b;
    @(posedge core_clk_i);
    #1 step = 1'b0;
    go = 1'b0;
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic t_req_mask;
    wr(4'hE, 8'h00);
    `CHK("unmask", 4'h0, chan_mask_o)
    for (int c = 0; c < 4; c++)
    begin
      wr(4'h9, 8'hFC | 8'(c));
      `CHK("req set", 4'h1 << c, soft_req_o)
      wr(4'h9, 8'(c));
      `CHK("req clr", 4'h0, soft_req_o)
      wr(4'hA, 8'hFC | 8'(c));
      `CHK("mask set", ~(4'hE << c), chan_mask_o)
    end
    wr(4'hA, 8'h01);
    `CHK("mask clr", 4'hD, chan_mask_o)
    $display("test req_mask done");
  endtask
  // software never writes type 11 here
  task automatic t_mode;
    for (int c = 0; c < 4; c++)
    begin
      wr(4'hB, {2'(c), 2'b11, 2'(c % 3), 2'(c)});
      `CHK("mode", 2'(c), mode_o[2*c +: 2])
      `CHK("untouched", 8'h00, mode_o >> (2*c + 2))
      `CHK("dir", 1'b1, address_step_direction_o[c])
      `CHK("auto init", 1'b1, auto_init_o[c])
      `CHK("type", 2'(c % 3), transfer_type_field_o[2*c +: 2])
    end
    // cascade with a write type: the type must still read as verify
    wr(4'hB, 8'hC7);
    `CHK("cascade mode", 2'b11, mode_o[7:6])
    `CHK("cascade type", 2'b00, transfer_type_field_o[7:6])
    controller_command_i = 8'h01;
    wr(4'hB, 8'h45);
    `CHK("copy type", 2'b00, transfer_type_field_o[3:2])
    controller_command_i = 8'h00;
    $display("test mode done");
  endtask
  task automatic t_ptr_temp;
    wr(4'hC, 8'h5A);
    `CHK("ptr clr", 1'b0, byte_pointer_toggle_o)
    eng(1'b1, 1'b0, 8'h00);
    `CHK("ptr high", 1'b1, byte_pointer_toggle_o)
    eng(1'b1, 1'b0, 8'h00);
    `CHK("ptr low", 1'b0, byte_pointer_toggle_o)
    eng(1'b1, 1'b1, 8'hA5);
    wr(4'hC, 8'h00);
    `CHK("ptr reclr", 1'b0, byte_pointer_toggle_o)
    rd(4'hD, 8'hA5);
    rd(4'h3, 8'h00);
    $display("test ptr_temp done");
  endtask
  task automatic t_mclr;
    wr(4'h9, 8'h05);
    wr(4'hD, 8'hFF);
    `CHK("mclr", 1'b1, software_master_clear_o)
    `CHK("regs", 20'hF0000, {chan_mask_o, soft_req_o, mode_o, 4'h0})
    rd(4'hD, 8'h00);
    `CHK("mclr end", 1'b0, software_master_clear_o)
    $display("test mclr done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    `CHK("reset masks", 4'hF, chan_mask_o)
    t_req_mask();
    t_mode();
    t_ptr_temp();
    t_mclr();
    end_of_test();
  end
endmodule // test_dcr_regs
bind dcr_regs dcr_regs_asserts #(.NUM_CH(NUM_CH)) u_chk (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .io_wr_i(io_wr_i),
  .io_addr_i(io_addr_i),
  .io_wdata_i(io_wdata_i),
  .controller_command_i(controller_command_i),
  .soft_req_o(soft_req_o),
  .chan_mask_o(chan_mask_o),
  .mode_o(mode_o),
  .transfer_type_field_o(transfer_type_field_o),
  .byte_pointer_toggle_o(byte_pointer_toggle_o),
  .software_master_clear_o(software_master_clear_o)
);
